// >>> dbu_pkg.sv
// Purpose: Shared constants and types for the DAC double-buffered update block
// Assumes: APB slave, 32-bit data, one clock
// Notes:   Functional notes below
//
// Functional notes
// - Delayed channel: write goes to holding buffer, output stays unchanged
// - Timing select: 0 updates output on write, 1 holds until update
// - Update event copies all delayed channels' held values together
// - Source select: 0 software update command, 1 external update strobe
// - Edge select: 0 falling edge, 1 rising edge of external strobe
// - Shared edge and source come from most recently configured channel
// - Polarity select: 1 unipolar, 0 bipolar
// - Stereo FIFO 32 bits by 16 words; two values per word
// - Stereo pacing at 16, 22.05, 24, 32, 44.1 or 48 kHz
// - Stereo data arrives serially or from local bus writes
// - Stereo path has no delayed mode; outputs bipolar at once
// - Reset leaves every channel bipolar with immediate update
// - Internal source: held values move only on software update command
// - Several writes before an update: only the latest is applied
`default_nettype none

package dbu_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int unsigned ADDR_W   = 8;
  localparam logic [7:0] OFS_CONFIG   = 8'h00;
  localparam logic [7:0] OFS_VALUE    = 8'h04;
  localparam logic [7:0] OFS_UPDATE   = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0c;
  localparam logic [7:0] OFS_STEREO   = 8'h10;
  localparam logic [7:0] OFS_FIFO     = 8'h14;
  localparam logic [7:0] OFS_OUT_BASE = 8'h20;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int unsigned CH_W          = 3;
  localparam int unsigned CFG_CH_LSB    = 0;
  localparam int unsigned CFG_POL_BIT   = 8;
  localparam int unsigned CFG_TIM_BIT   = 9;
  localparam int unsigned CFG_SRC_BIT   = 10;
  localparam int unsigned CFG_EDGE_BIT  = 11;
  localparam int unsigned VAL_W         = 16;
  localparam int unsigned VAL_CH_LSB    = 16;
  localparam int unsigned UPD_CMD_BIT   = 0;
  localparam int unsigned ST_PEND_LSB   = 8;
  localparam int unsigned ST_SRC_BIT    = 16;
  localparam int unsigned ST_EDGE_BIT   = 17;
  localparam int unsigned ST_CNT_LSB    = 24;
  localparam int unsigned ST_OVF_BIT    = 31;
  localparam int unsigned STR_RATE_LSB  = 0;
  localparam int unsigned STR_BOTH_BIT  = 4;

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic TIMING_IMMEDIATE = 1'b0;
  localparam logic TIMING_DELAYED   = 1'b1;
  localparam logic SRC_INTERNAL     = 1'b0;
  localparam logic SRC_EXTERNAL     = 1'b1;
  localparam logic EDGE_FALLING     = 1'b0;
  localparam logic EDGE_RISING      = 1'b1;
  localparam logic POL_UNIPOLAR     = 1'b1;
  localparam logic POL_BIPOLAR      = 1'b0;

  // ****************************************
  // Stereo FIFO and rates
  // ****************************************
  localparam int unsigned FIFO_W     = 32;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CNT_W      = 5;
  localparam int unsigned DIV_W      = 16;
  localparam int unsigned SER_BITS   = 32;
  localparam logic [2:0]  RATE_RESET = 3'h5;

  typedef struct packed {
    logic edge_sel;
    logic source_sel;
    logic timing_sel;
    logic polarity_sel;
  } dbu_cfg_t;

  localparam dbu_cfg_t CFG_RESET = '{EDGE_FALLING, SRC_INTERNAL, TIMING_IMMEDIATE, POL_BIPOLAR};

  typedef enum logic [1:0] {
    DBU_WAIT = 2'b01,
    DBU_HIGH = 2'b10
  } dbu_mono_t;

  function automatic int unsigned rate_hz(input logic [2:0] sel);
    case (sel)
      3'h0:    rate_hz = 16000;
      3'h1:    rate_hz = 22050;
      3'h2:    rate_hz = 24000;
      3'h3:    rate_hz = 32000;
      3'h4:    rate_hz = 44100;
      default: rate_hz = 48000;
    endcase
  endfunction

endpackage

`default_nettype wire

// >>> dbu_pair_buf.sv
// Purpose: Two-entry valid/ready buffer in the stereo data path
// Assumes: Same clock as its user
// Notes:   in_ready drops only when both entries hold data
`default_nettype none

module dbu_pair_buf #(
  parameter int unsigned W = 32
) (
  input  wire logic         mclk_i,
  input  wire logic         srst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  logic [W-1:0] slot [2];
  logic [1:0]   count;
  logic         rd_ptr;
  logic         wr_ptr;
  logic         push;
  logic         pop;

  assign in_ready_o  = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign out_data_o  = slot[rd_ptr];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      slot[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      count  <= 2'h0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push & ~pop) begin
        count <= count + 2'h1;
      end else if (pop & ~push) begin
        count <= count - 2'h1;
      end
    end
  end

endmodule

`default_nettype wire

// >>> dbu_dac_update.sv
// Purpose: DAC channel update control with double buffers and stereo FIFO path
// Assumes: APB slave; strobe and serial pins are asynchronous
// Notes:   CLK_HZ sets stereo pacing; lower it to shorten simulations
`default_nettype none

module dbu_dac_update import dbu_pkg::*; #(
  parameter int unsigned NCH    = 6,
  parameter int unsigned CLK_HZ = 100_000_000
) (
  input  wire logic                      mclk_i,
  input  wire logic                      srst_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [ADDR_W-1:0]         paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic [31:0]                    prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  input  wire logic                      external_update_strobe_i,
  input  wire logic                      ser_clk_i,
  input  wire logic                      ser_data_i,
  input  wire logic                      ser_frame_i,
  output logic [NCH-1:0][VAL_W-1:0]      dac_value_o,
  output logic [NCH-1:0]                 dac_unipolar_o,
  output logic                           update_pulse_o,
  output logic [VAL_W-1:0]               stereo_left_o,
  output logic [VAL_W-1:0]               stereo_right_o,
  output logic                           stereo_strobe_o
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic out_addr(input logic [ADDR_W-1:0] a);
    out_addr = (a >= OFS_OUT_BASE) && (a[1:0] == 2'h0) &&
               (32'(a - OFS_OUT_BASE) < 32'(NCH * 4));
  endfunction

  function automatic logic [CH_W-1:0] addr_ch(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - OFS_OUT_BASE;
    addr_ch = d[CH_W+1:2];
  endfunction

  function automatic logic [DIV_W-1:0] div_for(input logic [2:0] sel);
    div_for = DIV_W'(CLK_HZ / rate_hz(sel));
  endfunction

  // ****************************************
  // State
  // ****************************************
  dbu_cfg_t                 cfg [NCH];
  logic [VAL_W-1:0]         hold [NCH];
  logic [NCH-1:0]           pending;
  logic                     grp_source;
  logic                     grp_edge;
  logic [31:0]              last_cfg;
  logic [2:0]               rate_sel;
  logic                     stereo_both;
  logic                     overflow;
  logic [FIFO_W-1:0]        fifo_mem [FIFO_DEPTH];
  logic [3:0]               fifo_wp;
  logic [3:0]               fifo_rp;
  logic [CNT_W-1:0]         fifo_cnt;
  logic [2:0]               strobe_sync;
  logic [2:0]               sclk_sync;
  logic [2:0]               sdat_sync;
  logic [2:0]               sfrm_sync;
  logic [FIFO_W-1:0]        ser_shift;
  logic [5:0]               ser_bits;
  logic                     ser_pending;
  logic [FIFO_W-1:0]        ser_word;
  logic [DIV_W-1:0]         div_cnt;
  logic                     tick;
  dbu_mono_t                mono_state;
  logic [VAL_W-1:0]         mono_high;

  // ****************************************
  // APB access decode
  // ****************************************
  logic                     acc;
  logic                     done;
  logic                     mapped;
  logic                     fifo_addr;
  logic                     wr_cfg;
  logic                     wr_val;
  logic                     wr_upd;
  logic                     wr_stat;
  logic                     wr_str;
  logic                     wr_fifo;
  logic [CH_W-1:0]          cfg_ch;
  logic [CH_W-1:0]          val_ch;
  logic [VAL_W-1:0]         val_data;
  logic                     buf_in_ready;
  logic                     buf_in_valid;
  logic [FIFO_W-1:0]        buf_in_data;
  logic                     buf_out_valid;
  logic [FIFO_W-1:0]        buf_out_data;
  logic                     fifo_push;
  logic                     fifo_pop;
  logic                     ext_edge;
  logic                     update_evt;
  logic [31:0]              rd_data;
  logic                     ser_take;

  assign acc       = psel_i & penable_i;
  assign done      = acc & pready_o;
  assign fifo_addr = (paddr_i == OFS_FIFO);
  assign mapped    = (paddr_i == OFS_CONFIG) || (paddr_i == OFS_VALUE) ||
                     (paddr_i == OFS_UPDATE) || (paddr_i == OFS_STATUS) ||
                     (paddr_i == OFS_STEREO) || fifo_addr || out_addr(paddr_i);
  assign cfg_ch    = pwdata_i[CFG_CH_LSB +: CH_W];
  assign val_ch    = pwdata_i[VAL_CH_LSB +: CH_W];
  assign val_data  = pwdata_i[VAL_W-1:0];
  assign wr_cfg    = done & pwrite_i & (paddr_i == OFS_CONFIG) & (32'(cfg_ch) < NCH);
  assign wr_val    = done & pwrite_i & (paddr_i == OFS_VALUE) & (32'(val_ch) < NCH);
  assign wr_upd    = done & pwrite_i & (paddr_i == OFS_UPDATE) & pwdata_i[UPD_CMD_BIT];
  assign wr_stat   = done & pwrite_i & (paddr_i == OFS_STATUS);
  assign wr_str    = done & pwrite_i & (paddr_i == OFS_STEREO);
  assign wr_fifo   = done & pwrite_i & fifo_addr;

  always_comb begin
    rd_data = 32'h0000_0000;
    if (paddr_i == OFS_CONFIG) begin
      rd_data = last_cfg;
    end else if (paddr_i == OFS_STATUS) begin
      for (int i = 0; i < NCH; i++) begin
        rd_data[i]               = cfg[i].timing_sel;
        rd_data[ST_PEND_LSB + i] = pending[i];
      end
      rd_data[ST_SRC_BIT]              = grp_source;
      rd_data[ST_EDGE_BIT]             = grp_edge;
      rd_data[ST_CNT_LSB +: CNT_W]     = fifo_cnt;
      rd_data[ST_OVF_BIT]              = overflow;
    end else if (paddr_i == OFS_STEREO) begin
      rd_data[STR_RATE_LSB +: 3] = rate_sel;
      rd_data[STR_BOTH_BIT]      = stereo_both;
    end else if (out_addr(paddr_i)) begin
      rd_data[VAL_W-1:0] = dac_value_o[addr_ch(paddr_i)];
    end
  end

  // ****************************************
  // APB answer
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (pready_o) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (acc && (!(fifo_addr && pwrite_i) || buf_in_ready)) begin
      pready_o  <= 1'b1;
      prdata_o  <= rd_data;
      pslverr_o <= ~mapped;
    end
  end

  // ****************************************
  // Channel configuration
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      for (int i = 0; i < NCH; i++) begin
        cfg[i] <= CFG_RESET;
      end
      grp_source <= SRC_INTERNAL;
      grp_edge   <= EDGE_FALLING;
      last_cfg   <= 32'h0000_0000;
    end else if (wr_cfg) begin
      cfg[cfg_ch].polarity_sel <= pwdata_i[CFG_POL_BIT];
      cfg[cfg_ch].timing_sel   <= pwdata_i[CFG_TIM_BIT];
      cfg[cfg_ch].source_sel   <= pwdata_i[CFG_SRC_BIT];
      cfg[cfg_ch].edge_sel     <= pwdata_i[CFG_EDGE_BIT];
      grp_source <= pwdata_i[CFG_SRC_BIT];
      grp_edge   <= pwdata_i[CFG_EDGE_BIT];
      last_cfg   <= pwdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      dac_unipolar_o <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        dac_unipolar_o[i] <= (cfg[i].polarity_sel == POL_UNIPOLAR);
      end
    end
  end

  // ****************************************
  // External update strobe
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      strobe_sync <= 3'h0;
    end else begin
      strobe_sync <= {strobe_sync[1:0], external_update_strobe_i};
    end
  end

  // One pulse per qualifying edge of the settled level
  assign ext_edge = (grp_edge == EDGE_RISING) ? (strobe_sync[1] & ~strobe_sync[2])
                                               : (~strobe_sync[1] & strobe_sync[2]);
  assign update_evt = (grp_source == SRC_EXTERNAL) ? ext_edge : wr_upd;

  // ****************************************
  // Holding buffers and outputs
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      for (int i = 0; i < NCH; i++) begin
        hold[i] <= '0;
      end
      dac_value_o    <= '0;
      pending        <= '0;
      update_pulse_o <= 1'b0;
    end else begin
      update_pulse_o <= update_evt;
      if (update_evt) begin
        for (int i = 0; i < NCH; i++) begin
          if (cfg[i].timing_sel == TIMING_DELAYED) begin
            dac_value_o[i] <= hold[i];
          end
        end
        pending <= '0;
      end
      // Old held value goes out; a same-cycle write stays held
      if (wr_val) begin
        hold[val_ch] <= val_data;
        if (cfg[val_ch].timing_sel == TIMING_IMMEDIATE) begin
          dac_value_o[val_ch] <= val_data;
          pending[val_ch]     <= 1'b0;
        end else begin
          pending[val_ch] <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Serial intake
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sclk_sync <= 3'h0;
      sdat_sync <= 3'h0;
      sfrm_sync <= 3'h0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], ser_clk_i};
      sdat_sync <= {sdat_sync[1:0], ser_data_i};
      sfrm_sync <= {sfrm_sync[1:0], ser_frame_i};
    end
  end

  // Bus writes to the FIFO own the buffer while their access is open
  assign ser_take     = ser_pending & ~(acc & fifo_addr & pwrite_i);
  assign buf_in_valid = wr_fifo | ser_take;
  assign buf_in_data  = wr_fifo ? pwdata_i : ser_word;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ser_shift   <= '0;
      ser_bits    <= 6'h00;
      ser_pending <= 1'b0;
      ser_word    <= '0;
      overflow    <= 1'b0;
    end else begin
      if (ser_take && buf_in_ready) begin
        ser_pending <= 1'b0;
      end
      if (wr_stat && pwdata_i[ST_OVF_BIT]) begin
        overflow <= 1'b0;
      end
      if (!sfrm_sync[2]) begin
        ser_bits <= 6'h00;
      end else if (sclk_sync[1] && !sclk_sync[2]) begin
        if (ser_bits == 6'(SER_BITS - 1)) begin
          ser_word    <= {ser_shift[FIFO_W-2:0], sdat_sync[2]};
          ser_pending <= 1'b1;
          ser_bits    <= 6'h00;
          if (ser_pending && !(ser_take && buf_in_ready)) begin
            overflow <= 1'b1;
          end
        end else begin
          ser_bits <= ser_bits + 6'h01;
        end
        ser_shift <= {ser_shift[FIFO_W-2:0], sdat_sync[2]};
      end
    end
  end

  dbu_pair_buf #(
    .W (FIFO_W)
  ) u_buf (
    .mclk_i      (mclk_i),
    .srst_i      (srst_i),
    .in_valid_i  (buf_in_valid),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (buf_in_data),
    .out_valid_o (buf_out_valid),
    .out_ready_i (fifo_cnt != CNT_W'(FIFO_DEPTH)),
    .out_data_o  (buf_out_data)
  );

  // ****************************************
  // Stereo FIFO
  // ****************************************
  assign fifo_push = buf_out_valid & (fifo_cnt != CNT_W'(FIFO_DEPTH));

  always_ff @(posedge mclk_i) begin
    if (fifo_push) begin
      fifo_mem[fifo_wp] <= buf_out_data;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      fifo_wp  <= 4'h0;
      fifo_rp  <= 4'h0;
      fifo_cnt <= '0;
    end else begin
      if (fifo_push) begin
        fifo_wp <= fifo_wp + 4'h1;
      end
      if (fifo_pop) begin
        fifo_rp <= fifo_rp + 4'h1;
      end
      if (fifo_push && !fifo_pop) begin
        fifo_cnt <= fifo_cnt + CNT_W'(1);
      end else if (fifo_pop && !fifo_push) begin
        fifo_cnt <= fifo_cnt - CNT_W'(1);
      end
    end
  end

  // ****************************************
  // Conversion pacing
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rate_sel    <= RATE_RESET;
      stereo_both <= 1'b1;
    end else if (wr_str) begin
      rate_sel    <= pwdata_i[STR_RATE_LSB +: 3];
      stereo_both <= pwdata_i[STR_BOTH_BIT];
    end
  end

  assign tick = (div_cnt == '0);

  always_ff @(posedge mclk_i) begin
    if (srst_i || wr_str || tick) begin
      div_cnt <= div_for(srst_i ? RATE_RESET : (wr_str ? pwdata_i[2:0] : rate_sel))
                 - DIV_W'(1);
    end else begin
      div_cnt <= div_cnt - DIV_W'(1);
    end
  end

  assign fifo_pop = tick & (fifo_cnt != '0) & (stereo_both | (mono_state == DBU_WAIT));

  // Words carry left in the low half; mono plays low half then high half
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mono_state      <= DBU_WAIT;
      mono_high       <= '0;
      stereo_left_o   <= '0;
      stereo_right_o  <= '0;
      stereo_strobe_o <= 1'b0;
    end else begin
      stereo_strobe_o <= 1'b0;
      if (stereo_both) begin
        mono_state <= DBU_WAIT;
        if (fifo_pop) begin
          stereo_left_o   <= fifo_mem[fifo_rp][VAL_W-1:0];
          stereo_right_o  <= fifo_mem[fifo_rp][FIFO_W-1:VAL_W];
          stereo_strobe_o <= 1'b1;
        end
      end else begin
        case (mono_state)
          DBU_WAIT: begin
            if (fifo_pop) begin
              stereo_left_o   <= fifo_mem[fifo_rp][VAL_W-1:0];
              mono_high       <= fifo_mem[fifo_rp][FIFO_W-1:VAL_W];
              stereo_strobe_o <= 1'b1;
              mono_state      <= DBU_HIGH;
            end
          end
          DBU_HIGH: begin
            if (tick) begin
              stereo_left_o   <= mono_high;
              stereo_strobe_o <= 1'b1;
              mono_state      <= DBU_WAIT;
            end
          end
          default: begin
            mono_state <= DBU_WAIT;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// >>> dbu_dac_update_assertions.sv
// Purpose: Port checks for dbu_dac_update
// Assumes: One clock, sync reset
// Notes:   Bind after endmodule
`default_nettype none
module dbu_dac_update_assertions import dbu_pkg::*; #(
  parameter int unsigned NCH    = 6,
  parameter int unsigned CLK_HZ = 100_000_000
) (
  input wire logic                      mclk_i,
  input wire logic                      srst_i,
  input wire logic                      psel_i,
  input wire logic                      penable_i,
  input wire logic                      pwrite_i,
  input wire logic [ADDR_W-1:0]         paddr_i,
  input wire logic [31:0]               pwdata_i,
  input wire logic                      pready_o,
  input wire logic                      external_update_strobe_i,
  input wire logic [NCH-1:0][VAL_W-1:0] dac_value_o,
  input wire logic [NCH-1:0]            dac_unipolar_o,
  input wire logic                      update_pulse_o,
  input wire logic [VAL_W-1:0]          stereo_left_o,
  input wire logic                      stereo_strobe_o
);
  logic [3:0] since_pin;
  logic       pin_q;
  wire        wr  = psel_i && penable_i && pready_o && pwrite_i;
  wire        upd = wr && paddr_i == OFS_UPDATE && pwdata_i[UPD_CMD_BIT];
  wire        cfg = wr && paddr_i == OFS_CONFIG;
  // Cycles since the strobe pin last moved
  always_ff @(posedge mclk_i) begin
    pin_q <= external_update_strobe_i;
    if (srst_i || pin_q != external_update_strobe_i) since_pin <= '0;
    else if (since_pin != 4'hf) since_pin <= since_pin + 4'h1;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  sequence s_pulse; update_pulse_o; endsequence
  sequence s_ext_pulse; s_pulse ##0 !$past(upd); endsequence
  property p_val_cause;
    !$stable(dac_value_o) |-> $past(wr) || $past(wr, 2) || update_pulse_o;
  endproperty
  a_val_cause: assert property (p_val_cause) else $error("output moved without cause");
  property p_uni_cause;
    !$stable(dac_unipolar_o) |-> $past(cfg) || $past(cfg, 2);
  endproperty
  a_uni_cause: assert property (p_uni_cause) else $error("polarity moved alone");
  property p_upd_cause; s_pulse |-> $past(upd) || since_pin <= 4'h8; endproperty
  a_upd_cause: assert property (p_upd_cause) else $error("update without cause");
  property p_ext_sync; s_ext_pulse |-> since_pin >= 4'h2; endproperty
  a_ext_sync: assert property (p_ext_sync) else $error("strobe not synchronised");
  property p_upd_single; s_pulse |=> !update_pulse_o; endproperty
  a_upd_single: assert property (p_upd_single) else $error("update pulse too long");
  property p_pace; stereo_strobe_o |=> !stereo_strobe_o [*8]; endproperty
  a_pace: assert property (p_pace) else $error("conversions too close");
  property p_left; !$stable(stereo_left_o) |-> stereo_strobe_o || $past(stereo_strobe_o);
  endproperty
  a_left: assert property (p_left) else $error("left moved off strobe");
  property p_rst; $fell(srst_i) |-> dac_unipolar_o == '0 && dac_value_o == '0; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind dbu_dac_update dbu_dac_update_assertions #(.NCH(NCH), .CLK_HZ(CLK_HZ)) u_chk (
  .mclk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o,
  .external_update_strobe_i, .dac_value_o, .dac_unipolar_o, .update_pulse_o,
  .stereo_left_o, .stereo_strobe_o);
`default_nettype wire

// >>> dbu_strobe_src.sv
// Purpose: External update strobe source
// Assumes: Pin asynchronous to mclk_i
// Notes:   Level follows lvl_i after skew
`default_nettype none
module dbu_strobe_src (
  input  wire logic lvl_i,
  output var logic  strobe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial strobe_o = 1'b0;
  // Skew keeps edges off the clock
  always @(lvl_i) strobe_o <= #3 lvl_i;
endmodule
`default_nettype wire

// >>> test_dbu_dac_update.sv
// Purpose: Self-checking bench for dbu_dac_update
// Assumes: APB master in bench
// Notes:   Serial word driven by bench
`default_nettype none
module test_dbu_dac_update import dbu_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned NCH = 6;
  logic mclk_i = 1'b0, srst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd;
  logic pready_o, pslverr_o, er, ext_lvl = 1'b0, strobe, upd_o, sstb;
  logic sck = 1'b0, sdi = 1'b0, sfr = 1'b0;
  logic [NCH-1:0][VAL_W-1:0] dv;
  logic [NCH-1:0] uni;
  logic [VAL_W-1:0] sl, sr;
  int n_fail = 0, tests_run = 0, n_upd = 0;
  initial forever #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (upd_o === 1'b1) n_upd++;
  dbu_strobe_src u_src (.lvl_i(ext_lvl), .strobe_o(strobe));
  dbu_dac_update #(.NCH(NCH), .CLK_HZ(1_600_000)) dut (
    .mclk_i(mclk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .external_update_strobe_i(strobe),
    .ser_clk_i(sck), .ser_data_i(sdi), .ser_frame_i(sfr), .dac_value_o(dv),
    .dac_unipolar_o(uni), .update_pulse_o(upd_o), .stereo_left_o(sl),
    .stereo_right_o(sr), .stereo_strobe_o(sstb));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic cfg(input logic [2:0] c, input logic p, t, s, e);
    apb(1'b1, OFS_CONFIG, {20'h0, e, s, t, p, 5'h0, c});
  endtask
  task automatic wv(input logic [2:0] c, input logic [15:0] v);
    apb(1'b1, OFS_VALUE, {13'h0, c, v});
  endtask
  task automatic wstb(output int n);
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (sstb !== 1'b1 && n < 300);
    if (n >= 300) n_fail++;
  endtask
  task automatic t_reset();
    chk("unipolar", 32'(uni), '0);
    apb(1'b0, OFS_STATUS, '0);
    chk("delayed bits", rd & 32'h0003_003f, '0);
  endtask
  task automatic t_imm();
    cfg(3'h0, POL_BIPOLAR, TIMING_IMMEDIATE, SRC_INTERNAL, EDGE_FALLING);
    cfg(3'h1, POL_UNIPOLAR, TIMING_IMMEDIATE, SRC_INTERNAL, EDGE_FALLING);
    wv(3'h0, 16'h8001);
    idle(2);
    chk("ch0", 32'(dv[0]), 32'h8001);
    chk("unipolar", 32'(uni), 32'h2);
    apb(1'b1, 8'h18, 32'h0000_ffff);
    chk("unmapped", 32'(er), 32'h1);
    apb(1'b0, OFS_OUT_BASE, '0);
    chk("ch0 read", rd & 32'hffff, 32'h8001);
  endtask
  task automatic t_delay();
    cfg(3'h2, POL_BIPOLAR, TIMING_DELAYED, SRC_INTERNAL, EDGE_FALLING);
    cfg(3'h3, POL_BIPOLAR, TIMING_DELAYED, SRC_INTERNAL, EDGE_FALLING);
    wv(3'h2, 16'h1111);
    wv(3'h2, 16'h2222);
    wv(3'h3, 16'h3333);
    ext_lvl <= 1'b1;
    idle(8);
    chk("ch2 held", 32'(dv[2]), '0);
    chk("ch3 held", 32'(dv[3]), '0);
    apb(1'b1, OFS_UPDATE, 32'h1);
    idle(2);
    chk("ch2", 32'(dv[2]), 32'h2222);
    chk("ch3", 32'(dv[3]), 32'h3333);
  endtask
  task automatic t_ext();
    int u;
    cfg(3'h4, POL_BIPOLAR, TIMING_DELAYED, SRC_EXTERNAL, EDGE_FALLING);
    cfg(3'h5, POL_BIPOLAR, TIMING_DELAYED, SRC_EXTERNAL, EDGE_RISING);
    wv(3'h4, 16'h4444);
    apb(1'b1, OFS_UPDATE, 32'h1);
    ext_lvl <= 1'b0;
    idle(10);
    chk("cmd or fall", 32'(dv[4]), '0);
    u = n_upd;
    ext_lvl <= 1'b1;
    idle(10);
    chk("rise", 32'(dv[4]), 32'h4444);
    chk("one update", 32'(n_upd - u), 32'h1);
  endtask
  task automatic t_stereo();
    int n;
    apb(1'b1, OFS_STEREO, 32'h10);
    apb(1'b1, OFS_FIFO, 32'hbeef_1234);
    apb(1'b1, OFS_FIFO, 32'h5678_9abc);
    wstb(n);
    idle(1);
    chk("left", 32'(sl), 32'h1234);
    chk("right", 32'(sr), 32'hbeef);
    wstb(n);
    chk("pace", 32'(n + 1), 32'h64);
    chk("left 2", 32'(sl), 32'h9abc);
  endtask
  task automatic t_ser();
    localparam logic [31:0] SW = 32'h1357_2468;
    int n;
    apb(1'b1, OFS_STEREO, 32'h0);
    sfr <= 1'b1;
    for (int i = 31; i >= 0; i--) begin
      sdi <= SW[i];
      idle(2);
      sck <= 1'b1;
      idle(2);
      sck <= 1'b0;
    end
    sfr <= 1'b0;
    wstb(n);
    chk("ser word low", 32'(sl), 32'h2468);
    wstb(n);
    chk("mono high", 32'(sl), 32'h1357);
  endtask
  initial begin
    idle(3);
    srst_i <= 1'b0;
    t_reset();
    t_imm();
    t_delay();
    t_ext();
    t_stereo();
    t_ser();
    results();
  end
  initial begin
    #100us;
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
